// File: logic/prs_core.sv
// prs_core: program counter, its latches and the hardware return stack.
// assumes the decoder issues at most one command per cycle and that software
// keeps interrupts off while touching the pointer or top-of-stack registers.
`timescale 1ns/1ps
module prs_core
  import prs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // decoder command
  input wire prs_cmd_type cmd,
  // register port
  input wire prs_bus_type bus,
  output logic [7:0] rd_data,
  // fetch address and status
  output logic [20:0] program_counter,
  output logic stack_full,
  output logic stack_overflow,
  output logic stack_underflow
);

  typedef struct packed {
    logic [20:0] pc;
    logic [7:0] high_latch;
    logic [4:0] upper_latch;
    logic [4:0] ptr;
    logic ext_en;
    logic [7:0] rdata;
    logic pending_top;
    logic [2:0] top_sel;
  } prs_state_type;

  prs_state_type state_reg;
  prs_state_type state_next;

  logic [20:0] top_entry;
  logic mem_wr;
  logic [4:0] mem_wr_idx;
  logic [20:0] mem_wr_data;
  logic [4:0] mem_rd_idx;
  logic push;
  logic pop;
  logic set_ovf;
  logic set_unf;
  logic clr_ovf;
  logic clr_unf;
  logic [20:0] branch_delta;
  logic [20:0] top_mod;

  prs_stack_mem u_mem (
    .clk(clk),
    .wr_en(mem_wr),
    .wr_idx(mem_wr_idx),
    .wr_data(mem_wr_data),
    .rd_idx(mem_rd_idx),
    .rd_data(top_entry)
  );

  prs_flag_cell u_ovf (
    .clk(clk),
    .srst(srst),
    .set(set_ovf),
    .clr(clr_ovf),
    .flag(stack_overflow)
  );

  prs_flag_cell u_unf (
    .clk(clk),
    .srst(srst),
    .set(set_unf),
    .clr(clr_unf),
    .flag(stack_underflow)
  );

  // read index tracks the next pointer so top_entry is fresh every cycle
  assign mem_rd_idx = state_next.ptr;

  always_comb
  begin
    state_next = state_reg;
    push = 1'b0;
    pop = 1'b0;
    set_ovf = 1'b0;
    set_unf = 1'b0;
    clr_ovf = 1'b0;
    clr_unf = 1'b0;
    mem_wr = 1'b0;
    mem_wr_idx = state_reg.ptr;
    mem_wr_data = state_reg.pc;
    top_mod = top_entry;
    branch_delta = {{9{cmd.offset[10]}}, cmd.offset, 1'b0};

    case (cmd.op)
      PRS_OP_STEP: state_next.pc = state_reg.pc + PC_STEP_WORD;
      PRS_OP_STEP_LONG: state_next.pc = state_reg.pc + PC_STEP_LONG;
      PRS_OP_JUMP: state_next.pc = {cmd.word_addr, 1'b0};
      PRS_OP_CALL:
      begin
        push = 1'b1;
        state_next.pc = {cmd.word_addr, 1'b0};
      end
      PRS_OP_REL_CALL:
      begin
        push = 1'b1;
        state_next.pc = state_reg.pc + branch_delta;
      end
      PRS_OP_BRANCH: state_next.pc = state_reg.pc + branch_delta;
      PRS_OP_IRQ:
      begin
        push = 1'b1;
        state_next.pc = state_reg.pc;
      end
      PRS_OP_RETURN, PRS_OP_RETLIT, PRS_OP_RETINT: pop = 1'b1;
      PRS_OP_ADDULK, PRS_OP_SUBULK: pop = state_reg.ext_en;
      default: state_next.pc = state_reg.pc;
    endcase

    // push: pointer first, then the new entry takes the return address
    if (push)
    begin
      if (state_reg.ptr == PTR_FULL)
      begin
        set_ovf = 1'b1;
      end
      else
      begin
        state_next.ptr = state_reg.ptr + 5'h01;
        mem_wr = 1'b1;
        mem_wr_idx = state_reg.ptr + 5'h01;
        mem_wr_data = state_reg.pc;
      end
    end

    // pop: counter from current top, then pointer down; latches untouched
    if (pop)
    begin
      if (state_reg.ptr == PTR_RESET)
      begin
        set_unf = 1'b1;
      end
      else
      begin
        state_next.pc = {top_entry[20:1], 1'b0};
        state_next.ptr = state_reg.ptr - 5'h01;
      end
    end

    state_next.pending_top = 1'b0;
    state_next.rdata = 8'h00;

    if (bus.wr)
    begin
      case (bus.addr)
        REG_COUNTER_LOW:
        begin
          state_next.pc = {state_reg.upper_latch, state_reg.high_latch,
                           bus.wdata[7:1], 1'b0};
        end
        REG_HIGH_LATCH: state_next.high_latch = bus.wdata;
        REG_UPPER_LATCH: state_next.upper_latch = bus.wdata[4:0];
        REG_STACK_POINTER:
        begin
          state_next.ptr = bus.wdata[4:0];
          clr_ovf = ~bus.wdata[SPR_OVF_BIT];
          clr_unf = ~bus.wdata[SPR_UNF_BIT];
        end
        REG_TOP_LOW, REG_TOP_HIGH, REG_TOP_UPPER:
        begin
          // read-modify-write of the selected entry; slot zero is ignored
          if (bus.addr == REG_TOP_LOW)
          begin
            top_mod[7:0] = bus.wdata;
          end
          else if (bus.addr == REG_TOP_HIGH)
          begin
            top_mod[15:8] = bus.wdata;
          end
          else
          begin
            top_mod[20:16] = bus.wdata[4:0];
          end
          mem_wr = (state_reg.ptr != PTR_RESET);
          mem_wr_idx = state_reg.ptr;
          mem_wr_data = top_mod;
        end
        REG_CONTROL: state_next.ext_en = bus.wdata[CTL_EXT_BIT];
        default: state_next.ext_en = state_reg.ext_en;
      endcase
    end

    if (bus.rd)
    begin
      case (bus.addr)
        REG_COUNTER_LOW:
        begin
          state_next.rdata = state_reg.pc[7:0];
          state_next.high_latch = state_reg.pc[15:8];
          state_next.upper_latch = state_reg.pc[20:16];
        end
        REG_HIGH_LATCH: state_next.rdata = state_reg.high_latch;
        REG_UPPER_LATCH: state_next.rdata = {3'h0, state_reg.upper_latch};
        REG_STACK_POINTER:
        begin
          state_next.rdata = {stack_full, stack_overflow, stack_underflow,
                              state_reg.ptr};
        end
        REG_TOP_LOW, REG_TOP_HIGH, REG_TOP_UPPER:
        begin
          // entry data arrive from the memory register one cycle on
          state_next.pending_top = 1'b1;
          state_next.top_sel = bus.addr[2:0];
        end
        REG_CONTROL: state_next.rdata = {7'h00, state_reg.ext_en};
        default: state_next.rdata = 8'h00;
      endcase
    end

    if (srst)
    begin
      state_next.pc = PC_RESET;
      state_next.high_latch = LATCH_RESET;
      state_next.upper_latch = LATCH_RESET[4:0];
      state_next.ptr = PTR_RESET;
      state_next.ext_en = 1'b0;
      state_next.rdata = 8'h00;
      state_next.pending_top = 1'b0;
      state_next.top_sel = 3'h0;
    end
  end

  always_ff @(posedge clk)
  begin
    state_reg <= state_next;
  end

  // top entry reads register the stored value for the cycle after the strobe
  always_comb
  begin
    rd_data = state_reg.rdata;
    if (state_reg.pending_top)
    begin
      case (state_reg.top_sel)
        REG_TOP_LOW[2:0]: rd_data = top_entry[7:0];
        REG_TOP_HIGH[2:0]: rd_data = top_entry[15:8];
        REG_TOP_UPPER[2:0]: rd_data = {3'h0, top_entry[20:16]};
        default: rd_data = 8'h00;
      endcase
    end
  end

  assign program_counter = state_reg.pc;
  assign stack_full = (state_reg.ptr == PTR_FULL);

  chk_pc_even: assert property (@(posedge clk) disable iff (srst)
    program_counter[0] == 1'b0) else $error("counter bit 0 set");

  chk_step_two: assert property (@(posedge clk) disable iff (srst)
    (cmd.op == PRS_OP_STEP && !bus.wr) |=> program_counter == $past(program_counter) + 21'h2)
    else $error("step did not add two");

  chk_low_write: assert property (@(posedge clk) disable iff (srst)
    (bus.wr && bus.addr == REG_COUNTER_LOW) |=>
    program_counter[20:8] == {$past(state_reg.upper_latch), $past(state_reg.high_latch)})
    else $error("latches not copied on low write");

  chk_low_read: assert property (@(posedge clk) disable iff (srst)
    (bus.rd && bus.addr == REG_COUNTER_LOW && !bus.wr) |=>
    state_reg.high_latch == $past(program_counter[15:8]))
    else $error("high latch not captured on read");

  chk_upper_capture: assert property (@(posedge clk) disable iff (srst)
    (bus.rd && bus.addr == REG_COUNTER_LOW && !bus.wr) |=>
    state_reg.upper_latch == $past(program_counter[20:16]))
    else $error("upper latch not captured on read");

  chk_call_latch: assert property (@(posedge clk) disable iff (srst)
    (cmd.op inside {PRS_OP_CALL, PRS_OP_RETURN} && !bus.wr && !bus.rd) |=>
    $stable(state_reg.high_latch) && $stable(state_reg.upper_latch))
    else $error("call or return moved a latch");

  chk_jump_load: assert property (@(posedge clk) disable iff (srst)
    (cmd.op == PRS_OP_JUMP && !bus.wr) |=> program_counter == {$past(cmd.word_addr), 1'b0})
    else $error("jump did not load word address");

  chk_branch_scale: assert property (@(posedge clk) disable iff (srst)
    (cmd.op == PRS_OP_BRANCH && !bus.wr) |=> program_counter ==
    $past(program_counter) + {{9{$past(cmd.offset[10])}}, $past(cmd.offset), 1'b0})
    else $error("branch offset not scaled by two");

  chk_push_ptr: assert property (@(posedge clk) disable iff (srst)
    (cmd.op == PRS_OP_CALL && !stack_full && !bus.wr) |=>
    state_reg.ptr == $past(state_reg.ptr) + 5'h01) else $error("push pointer");

  chk_irq_push: assert property (@(posedge clk) disable iff (srst)
    (cmd.op == PRS_OP_IRQ && !stack_full && !bus.wr) |=>
    state_reg.ptr == $past(state_reg.ptr) + 5'h01 && program_counter == $past(program_counter))
    else $error("interrupt push");

  chk_pop_ptr: assert property (@(posedge clk) disable iff (srst)
    (cmd.op inside {PRS_OP_RETURN, PRS_OP_RETLIT, PRS_OP_RETINT} && !bus.wr &&
    state_reg.ptr != PTR_RESET) |=> state_reg.ptr == $past(state_reg.ptr) - 5'h01)
    else $error("pop pointer");

  chk_unlink_gate: assert property (@(posedge clk) disable iff (srst)
    (cmd.op inside {PRS_OP_ADDULK, PRS_OP_SUBULK} && !state_reg.ext_en && !bus.wr) |=>
    state_reg.ptr == $past(state_reg.ptr))
    else $error("unlink popped with extended set off");

  chk_call_return: assert property (@(posedge clk) disable iff (srst)
    (cmd.op == PRS_OP_CALL && !stack_full && !bus.wr) ##1
    (cmd.op == PRS_OP_RETURN && !bus.wr) |=> program_counter == $past(program_counter, 2))
    else $error("return lost call address");

  chk_overflow: assert property (@(posedge clk) disable iff (srst)
    (cmd.op == PRS_OP_CALL && stack_full && !bus.wr) |=> stack_overflow && stack_full)
    else $error("overflow not flagged");

  chk_underflow: assert property (@(posedge clk) disable iff (srst)
    (cmd.op == PRS_OP_RETURN && state_reg.ptr == PTR_RESET && !bus.wr) |=>
    stack_underflow && state_reg.ptr == PTR_RESET) else $error("underflow not flagged");

  chk_reset_ptr: assert property (@(posedge clk)
    srst |=> state_reg.ptr == PTR_RESET) else $error("pointer not cleared");

endmodule : prs_core

// File: logic/prs_pkg.sv
// prs_pkg: constants, encodings and carriers for the program counter and return stack.
// assumes a single core clock; imported whole by every design file of this block.
package prs_pkg;

  localparam int PC_WIDTH = 21;
  localparam int PTR_WIDTH = 5;
  localparam int STACK_DEPTH = 31;
  localparam logic [4:0] PTR_RESET = 5'h00;
  localparam logic [4:0] PTR_FULL = 5'h1f;
  localparam logic [20:0] PC_RESET = 21'h000000;
  localparam logic [20:0] PC_STEP_WORD = 21'h000002;
  localparam logic [20:0] PC_STEP_LONG = 21'h000004;
  localparam logic [7:0] LATCH_RESET = 8'h00;

  // register offsets on the plain register port
  localparam logic [3:0] REG_COUNTER_LOW = 4'h0;
  localparam logic [3:0] REG_HIGH_LATCH = 4'h1;
  localparam logic [3:0] REG_UPPER_LATCH = 4'h2;
  localparam logic [3:0] REG_STACK_POINTER = 4'h3;
  localparam logic [3:0] REG_TOP_LOW = 4'h4;
  localparam logic [3:0] REG_TOP_HIGH = 4'h5;
  localparam logic [3:0] REG_TOP_UPPER = 4'h6;
  localparam logic [3:0] REG_CONTROL = 4'h7;

  // pointer register field layout
  localparam int SPR_FULL_BIT = 7;
  localparam int SPR_OVF_BIT = 6;
  localparam int SPR_UNF_BIT = 5;
  // control register field layout
  localparam int CTL_EXT_BIT = 0;

  typedef enum logic [3:0] {
    PRS_OP_NONE = 4'h0,
    PRS_OP_STEP = 4'h1,
    PRS_OP_STEP_LONG = 4'h2,
    PRS_OP_JUMP = 4'h3,
    PRS_OP_CALL = 4'h4,
    PRS_OP_REL_CALL = 4'h5,
    PRS_OP_BRANCH = 4'h6,
    PRS_OP_RETURN = 4'h7,
    PRS_OP_RETLIT = 4'h8,
    PRS_OP_RETINT = 4'h9,
    PRS_OP_ADDULK = 4'ha,
    PRS_OP_SUBULK = 4'hb,
    PRS_OP_IRQ = 4'hc
  } prs_op_type;

  typedef struct packed {
    prs_op_type op;
    logic [19:0] word_addr;
    logic [10:0] offset;
  } prs_cmd_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } prs_bus_type;

endpackage : prs_pkg

// File: logic/prs_stack_mem.sv
// prs_stack_mem: 31 x 21 return address storage with registered read data.
// ignores writes to index 0; it has no storage and reads zero.
`timescale 1ns/1ps
module prs_stack_mem
  import prs_pkg::*;
(
  // clock
  input wire logic clk,
  // write side
  input wire logic wr_en,
  input wire logic [4:0] wr_idx,
  input wire logic [20:0] wr_data,
  // read side
  input wire logic [4:0] rd_idx,
  output logic [20:0] rd_data
);

  logic [20:0] mem [1:STACK_DEPTH];

  always_ff @(posedge clk)
  begin
    if (wr_en && wr_idx != PTR_RESET)
    begin
      mem[wr_idx] <= wr_data;
    end
    if (rd_idx == PTR_RESET)
    begin
      rd_data <= PC_RESET;
    end
    else if (wr_en && wr_idx == rd_idx)
    begin
      rd_data <= wr_data;
    end
    else
    begin
      rd_data <= mem[rd_idx];
    end
  end

endmodule : prs_stack_mem

// File: logic/prs_flag_cell.sv
// prs_flag_cell: sticky status flag, hardware set beats software clear.
// assumes clear arrives as a one-cycle request from the register port.
`timescale 1ns/1ps
module prs_flag_cell
  import prs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control
  input wire logic set,
  input wire logic clr,
  // state
  output logic flag
);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      flag <= 1'b0;
    end
    else if (set)
    begin
      flag <= 1'b1;
    end
    else if (clr)
    begin
      flag <= 1'b0;
    end
  end

endmodule : prs_flag_cell

// File: testbench/prs_soft_model.sv
// prs_soft_model: decoder and software side, issuing commands and register cycles.
// assumes one core clock; everything changes by non-blocking assignment after a rising edge.
`timescale 1ns/1ps
module prs_soft_model
  import prs_pkg::*;
(
  // clock
  input wire logic clk,
  // toward the core
  output prs_cmd_type cmd,
  output prs_bus_type bus,
  input wire logic [7:0] rd_data
);
  initial
  begin
    cmd = '0;
    bus = '0;
  end

  // one command for one cycle, then idle
  task automatic issue(input prs_op_type op, input logic [19:0] wa, input logic [10:0] off);
    @(posedge clk);
    cmd <= '{op: op, word_addr: wa, offset: off};
    @(posedge clk);
    cmd <= '0;
    #1;
  endtask : issue

  // two commands on consecutive edges, so a return meets the entry just pushed
  task automatic issue2(input prs_op_type op_a, input logic [19:0] wa, input prs_op_type op_b);
    @(posedge clk);
    cmd <= '{op: op_a, word_addr: wa, offset: 11'h000};
    @(posedge clk);
    cmd <= '{op: op_b, word_addr: 20'h00000, offset: 11'h000};
    @(posedge clk);
    cmd <= '0;
    #1;
  endtask : issue2

  // command port is idle for the whole cycle, so no interrupt push can slip
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
    #1;
  endtask : wr

  // data stands only in the cycle after the strobe edge
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    d = rd_data;
  endtask : rd
endmodule : prs_soft_model

// File: testbench/prs_core_bench.sv
// prs_core_bench: self-checking bench for the program counter and return stack.
// assumes the soft model drives command and register port; expectations are hand derived.
`timescale 1ns/1ps
module prs_core_bench
  import prs_pkg::*;
;
  logic clk;
  logic srst;
  prs_cmd_type cmd;
  prs_bus_type bus;
  logic [7:0] rd_data;
  logic [20:0] program_counter;
  logic stack_full;
  logic stack_overflow;
  logic stack_underflow;
  int miscompares;
  int n_checks;
  logic [7:0] d;
  logic [20:0] pc_keep;

  prs_core prs_core_i (.clk(clk), .srst(srst), .cmd(cmd), .bus(bus), .rd_data(rd_data),
    .program_counter(program_counter), .stack_full(stack_full),
    .stack_overflow(stack_overflow), .stack_underflow(stack_underflow));
  prs_soft_model prs_soft_model_i (.clk(clk), .cmd(cmd), .bus(bus), .rd_data(rd_data));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string name, input logic [20:0] exp, input logic [20:0] got);
    n_checks++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  task automatic t_seq;
    prs_soft_model_i.issue(PRS_OP_JUMP, 20'h12345, 11'h000);
    chk("jump", 21'h02468a, program_counter);
    prs_soft_model_i.issue(PRS_OP_STEP, 20'h0, 11'h000);
    chk("step", 21'h02468c, program_counter);
    prs_soft_model_i.issue(PRS_OP_STEP_LONG, 20'h0, 11'h000);
    chk("step long", 21'h024690, program_counter);
    prs_soft_model_i.issue(PRS_OP_BRANCH, 20'h0, 11'h7fe);
    chk("branch", 21'h02468c, program_counter);
    $display("test seq done");
  endtask : t_seq

  task automatic t_latch;
    prs_soft_model_i.rd(REG_COUNTER_LOW, d);
    chk("low byte", 21'(8'h8c), 21'(d));
    prs_soft_model_i.rd(REG_HIGH_LATCH, d);
    chk("high latch", 21'(8'h46), 21'(d));
    prs_soft_model_i.rd(REG_UPPER_LATCH, d);
    chk("upper latch", 21'(8'h02), 21'(d));
    prs_soft_model_i.wr(REG_HIGH_LATCH, 8'h12);
    prs_soft_model_i.wr(REG_UPPER_LATCH, 8'h05);
    chk("latch only", 21'h02468c, program_counter);
    prs_soft_model_i.wr(REG_COUNTER_LOW, 8'h33);
    chk("low write", 21'h051232, program_counter);
    $display("test latch done");
  endtask : t_latch

  task automatic t_stack;
    prs_op_type push_op[3] = '{PRS_OP_CALL, PRS_OP_REL_CALL, PRS_OP_IRQ};
    prs_op_type pop_op[3] = '{PRS_OP_RETINT, PRS_OP_RETLIT, PRS_OP_RETURN};
    logic [20:0] pushed[3] = '{21'h0a, 21'h06, 21'h0e};
    logic [20:0] after[3] = '{21'h06, 21'h0e, 21'h0e};
    prs_soft_model_i.issue(PRS_OP_JUMP, 20'h00005, 11'h000);
    for (int i = 0; i < 3; i++)
    begin
      prs_soft_model_i.issue(push_op[i], 20'h00003, 11'h004);
      chk("push pc", after[i], program_counter);
      prs_soft_model_i.rd(REG_STACK_POINTER, d);
      chk("push ptr", 21'(i + 1), 21'(d));
      prs_soft_model_i.rd(REG_TOP_LOW, d);
      chk("pushed", pushed[i], 21'(d));
    end
    prs_soft_model_i.rd(REG_HIGH_LATCH, d);
    chk("latch kept", 21'(8'h12), 21'(d));
    for (int i = 0; i < 3; i++)
    begin
      prs_soft_model_i.issue(pop_op[i], 20'h0, 11'h000);
      chk("pop pc", pushed[2 - i], program_counter);
      prs_soft_model_i.rd(REG_STACK_POINTER, d);
      chk("pop ptr", 21'(2 - i), 21'(d));
    end
    prs_soft_model_i.rd(REG_UPPER_LATCH, d);
    chk("latch kept", 21'(8'h05), 21'(d));
    prs_soft_model_i.issue2(PRS_OP_CALL, 20'h00010, PRS_OP_RETURN);
    chk("call return", 21'h00000a, program_counter);
    prs_soft_model_i.rd(REG_STACK_POINTER, d);
    chk("pair ptr", 21'h0, 21'(d));
    $display("test stack done");
  endtask : t_stack

  task automatic t_limits;
    prs_soft_model_i.wr(REG_STACK_POINTER, 8'h1f);
    chk("full", 21'(1'b1), 21'(stack_full));
    prs_soft_model_i.issue(PRS_OP_CALL, 20'h00003, 11'h000);
    chk("overflow", 21'(1'b1), 21'(stack_overflow));
    prs_soft_model_i.rd(REG_STACK_POINTER, d);
    chk("ptr status", 21'(8'hdf), 21'(d));
    prs_soft_model_i.wr(REG_STACK_POINTER, 8'h00);
    chk("flags clear", 21'h0, 21'({stack_full, stack_overflow}));
    pc_keep = program_counter;
    prs_soft_model_i.issue(PRS_OP_RETURN, 20'h0, 11'h000);
    chk("underflow", 21'(1'b1), 21'(stack_underflow));
    chk("pc held", pc_keep, program_counter);
    prs_soft_model_i.wr(REG_STACK_POINTER, 8'h00);
    chk("unf clear", 21'h0, 21'(stack_underflow));
    $display("test limits done");
  endtask : t_limits

  task automatic t_ext;
    prs_soft_model_i.wr(REG_CONTROL, 8'h00);
    prs_soft_model_i.issue(PRS_OP_CALL, 20'h00008, 11'h000);
    prs_soft_model_i.wr(REG_TOP_LOW, 8'h44);
    prs_soft_model_i.wr(REG_TOP_HIGH, 8'h33);
    prs_soft_model_i.wr(REG_TOP_UPPER, 8'h01);
    prs_soft_model_i.rd(REG_TOP_HIGH, d);
    chk("top write", 21'(8'h33), 21'(d));
    prs_soft_model_i.issue(PRS_OP_ADDULK, 20'h0, 11'h000);
    prs_soft_model_i.rd(REG_STACK_POINTER, d);
    chk("unlink off", 21'(8'h01), 21'(d));
    prs_soft_model_i.wr(REG_CONTROL, 8'h01);
    prs_soft_model_i.rd(REG_CONTROL, d);
    chk("control", 21'(8'h01), 21'(d));
    prs_soft_model_i.issue(PRS_OP_SUBULK, 20'h0, 11'h000);
    chk("unlink pop", 21'h013344, program_counter);
    prs_soft_model_i.rd(REG_TOP_LOW, d);
    chk("slot zero", 21'h0, 21'(d));
    prs_soft_model_i.rd(4'h9, d);
    chk("unmapped", 21'h0, 21'(d));
    prs_soft_model_i.issue(PRS_OP_IRQ, 20'h0, 11'h000);
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    prs_soft_model_i.rd(REG_STACK_POINTER, d);
    chk("reset ptr", 21'h0, 21'(d));
    $display("test ext done");
  endtask : t_ext

  initial
  begin
    srst = 1'b1;
    miscompares = 0;
    n_checks = 0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    #1;
    chk("reset pc", 21'h0, program_counter);
    t_seq();
    t_latch();
    t_stack();
    t_limits();
    t_ext();
    end_sim();
  end

  // whole run is about 120 cycles
  initial
  begin
    #(4 * 5000);
    miscompares++;
    end_sim();
  end
endmodule : prs_core_bench
